// ===== core/boot_flash_access_guard.sv
// The register addresses and the APB slave port are this design's own decisions.
`include "boot_flash_guard_regs.svh"
`default_nettype none
module boot_flash_access_guard (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// core side, same clock
	input  wire logic [13:0] fetch_addr_in,
	input  wire logic        store_exec_in,
	input  wire logic [15:0] store_data_in,
	input  wire logic        load_exec_in,
	input  wire logic        vectors_in_loader_in,
	output logic             halt_core_out,
	output logic             rww_busy_flag_out,
	output logic             irq_disable_out,
	output logic             load_allow_out,
	output logic             load_valid_out,
	output logic      [13:0] load_word_out,
	output logic             load_byte_sel_out,
	output logic      [13:0] reset_vector_out,
	// flash array side
	input  wire logic        flash_done_in,
	output logic             flash_erase_out,
	output logic             flash_write_out,
	output logic      [7:0]  flash_page_out,
	output logic             buf_write_out,
	output logic      [5:0]  buf_word_out,
	output logic      [15:0] buf_data_out,
	output logic      [3:0]  lock_bits_out,
	// pins from the programming interface and non-volatile cells
	input  wire logic        boot_reset_fuse_pin_in,
	input  wire logic [3:0]  nv_lock_pin_in,
	input  wire logic [3:0]  prog_lock_pin_in,
	input  wire logic        chip_erase_pin_in,
	input  wire logic [1:0]  gen_lock_mode_pin_in
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [11:0] sync1_ff;
	logic [11:0] sync2_ff;
	logic        erase_dly_ff;

	wire [11:0] pin_bundle = {gen_lock_mode_pin_in, chip_erase_pin_in, prog_lock_pin_in,
		nv_lock_pin_in, boot_reset_fuse_pin_in};

	// only the second stage is read; the first may still be settling
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_ff     <= 12'h000;
			sync2_ff     <= 12'h000;
			erase_dly_ff <= 1'b0;
		end else begin
			sync1_ff     <= pin_bundle;
			sync2_ff     <= sync1_ff;
			erase_dly_ff <= sync2_ff[9];
		end
	end

	wire       fuse_s       = sync2_ff[0];
	wire [3:0] nv_lock_s    = sync2_ff[4:1];
	wire [3:0] prog_lock_s  = sync2_ff[8:5];
	wire       chip_erase_p = sync2_ff[9] & ~erase_dly_ff;
	// general lock mode is visible in status only and gates nothing here
	wire [1:0] gen_lock_s   = sync2_ff[11:10];

	////////////////////////////////////////////////////////////////////////////////
	// capture of fuse and lock cells after reset release

	logic [1:0]  capture_cnt_ff;
	logic        captured_ff;
	logic        boot_fuse_ff;
	logic [1:0]  app_lock_ff;
	logic [1:0]  loader_lock_ff;
	logic [13:0] reset_vector_ff;

	// locks read fully programmed until capture, so early erases, writes and loads across sections stay shut
	wire capture_now = ~captured_ff & (capture_cnt_ff == `CAPTURE_CYCLES);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			capture_cnt_ff <= 2'h0;
			captured_ff    <= 1'b0;
			boot_fuse_ff   <= 1'b1;
		end else if (!captured_ff) begin
			capture_cnt_ff <= capture_cnt_ff + 2'h1;
			if (capture_now) begin
				captured_ff  <= 1'b1;
				boot_fuse_ff <= fuse_s;
			end
		end
	end

	// vector is taken from the captured fuse, no register write reaches it
	wire [13:0] nxt_reset_vector = boot_fuse_ff ? `APP_RESET_VECTOR
		: `LOADER_START;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			reset_vector_ff <= `APP_RESET_VECTOR;
		else
			reset_vector_ff <= nxt_reset_vector;
	end

	////////////////////////////////////////////////////////////////////////////////
	// section decode

	// one boundary serves both the loader section and the no-read-while-write region
	wire exec_in_loader = (fetch_addr_in >= `LOADER_START);

	logic [15:0] pointer_ff;
	logic [7:0]  lock_data_ff;

	// pointer holds a byte address: bit 0 byte, then word in page, then page
	wire [5:0]  ptr_word = pointer_ff[`WORD_BITS:1];
	// pointer bit 15 lies beyond the array and only reads back
	wire [7:0]  ptr_page = pointer_ff[14:`WORD_BITS+1];
	wire [13:0] ptr_word_addr = pointer_ff[14:1];
	wire        target_loader = (ptr_word_addr >= `LOADER_START);
	wire        target_nrw    = (ptr_word_addr >= `NRW_START);

	////////////////////////////////////////////////////////////////////////////////
	// lock gating

	wire app_store_open    = app_lock_ff[0];
	wire loader_store_open = loader_lock_ff[0];
	// field value 11 opens both paths, other bits only close their own
	wire store_lock_ok = target_loader ? loader_store_open : app_store_open;

	wire load_blocked_app    = exec_in_loader & ~target_loader & ~app_lock_ff[1];
	wire load_blocked_loader = ~exec_in_loader & target_loader & ~loader_lock_ff[1];
	wire load_ok = ~(load_blocked_app | load_blocked_loader);

	wire irq_mask_app    = ~exec_in_loader & vectors_in_loader_in & ~app_lock_ff[1];
	wire irq_mask_loader = exec_in_loader & ~vectors_in_loader_in & ~loader_lock_ff[1];

	////////////////////////////////////////////////////////////////////////////////
	// command register and store window

	boot_flash_guard_pkg::op_state_t state_ff;
	logic [4:0] cmd_ff;
	logic [2:0] window_ff;
	logic       rww_busy_ff;
	logic       nrw_op_ff;
	logic [7:0] page_ff;

	wire apb_access  = psel_in & penable_in;
	wire apb_wr      = apb_access & pwrite_in;
	wire hit_ctrl    = (paddr_in == `REG_CTRL);
	wire hit_pointer = (paddr_in == `REG_POINTER);
	wire hit_ldata   = (paddr_in == `REG_LOCK_DATA);
	wire hit_status  = (paddr_in == `REG_STATUS);
	wire hit_any     = hit_ctrl | hit_pointer | hit_ldata | hit_status;

	wire op_busy  = (state_ff != boot_flash_guard_pkg::ST_IDLE);
	wire [4:0] wr_cmd = pwdata_in[4:0];
	wire cmd_legal = (wr_cmd == `CMD_FILL) | (wr_cmd == `CMD_ERASE) | (wr_cmd == `CMD_WRITE)
		| (wr_cmd == `CMD_LOCKSET) | (wr_cmd == `CMD_REENABLE);
	wire ctrl_wr   = apb_wr & hit_ctrl & cmd_legal & ~op_busy;

	// a store counts only while the window is open and it runs from the loader
	wire store_ok  = store_exec_in & (window_ff != 3'h0) & exec_in_loader;
	wire go_erase  = store_ok & (cmd_ff == `CMD_ERASE) & store_lock_ok;
	wire go_write  = store_ok & (cmd_ff == `CMD_WRITE) & store_lock_ok;
	// fill reaches the page buffer only; the locks guard the erase and write after it
	wire go_fill   = store_ok & (cmd_ff == `CMD_FILL);
	wire go_lock   = store_ok & (cmd_ff == `CMD_LOCKSET);
	wire go_reen   = store_ok & (cmd_ff == `CMD_REENABLE);
	wire go_op     = go_erase | go_write;
	// the last open cycle closes the window, so a store one edge later finds it shut
	wire window_last = (window_ff == 3'h1);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_ff    <= 5'h00;
			window_ff <= 3'h0;
		end else if (ctrl_wr) begin
			cmd_ff    <= wr_cmd;
			window_ff <= `STORE_WINDOW_CYCLES;
		end else if (op_busy) begin
			if (flash_done_in)
				cmd_ff <= 5'h00;
		end else if (go_op) begin
			window_ff <= 3'h0;
		end else if (store_ok || window_last) begin
			cmd_ff    <= 5'h00;
			window_ff <= 3'h0;
		end else if (window_ff != 3'h0) begin
			window_ff <= window_ff - 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// programming operation

	// page and region freeze at start; the pointer is free again while the operation runs
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff  <= boot_flash_guard_pkg::ST_IDLE;
			page_ff   <= 8'h00;
			nrw_op_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				boot_flash_guard_pkg::ST_IDLE: begin
					if (go_op) begin
						state_ff  <= go_erase ? boot_flash_guard_pkg::ST_ERASE
							: boot_flash_guard_pkg::ST_WRITE;
						page_ff   <= ptr_page;
						nrw_op_ff <= target_nrw;
					end
				end
				boot_flash_guard_pkg::ST_ERASE,
				boot_flash_guard_pkg::ST_WRITE: begin
					if (flash_done_in) begin
						state_ff  <= boot_flash_guard_pkg::ST_IDLE;
						nrw_op_ff <= 1'b0;
					end
				end
			endcase
		end
	end

	// busy flag: set at start of an operation outside the no-read-while-write region, cleared only by the re-enable store once idle; set wins
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			rww_busy_ff <= 1'b0;
		else if (go_op && !target_nrw)
			rww_busy_ff <= 1'b1;
		else if (go_reen && !op_busy)
			rww_busy_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// lock fields

	wire [1:0] sw_app    = {lock_data_ff[3], lock_data_ff[2]};
	wire [1:0] sw_loader = {lock_data_ff[5], lock_data_ff[4]};
	// bits only move toward programmed here; each field on its own
	wire [1:0] nxt_app_lock    = app_lock_ff & prog_lock_s[1:0]
		& (go_lock ? sw_app : 2'h3);
	wire [1:0] nxt_loader_lock = loader_lock_ff & prog_lock_s[3:2]
		& (go_lock ? sw_loader : 2'h3);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			app_lock_ff    <= `LOCK_RESET;
			loader_lock_ff <= `LOCK_RESET;
		end else if (capture_now) begin
			app_lock_ff    <= nv_lock_s[1:0];
			loader_lock_ff <= nv_lock_s[3:2];
		end else if (chip_erase_p) begin
			// a chip erase is the only way back to unprogrammed
			app_lock_ff    <= 2'h3;
			loader_lock_ff <= 2'h3;
		end else if (captured_ff) begin
			app_lock_ff    <= nxt_app_lock;
			loader_lock_ff <= nxt_loader_lock;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// core and flash outputs

	// array pulses last one cycle; the array keeps its own cell timing
	logic        erase_p_ff;
	logic        write_p_ff;
	logic        buf_wr_ff;
	logic [5:0]  buf_word_ff;
	logic [15:0] buf_data_ff;
	logic        load_valid_ff;
	logic        load_allow_ff;
	logic [13:0] load_word_ff;
	logic        load_byte_ff;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			erase_p_ff <= 1'b0;
			write_p_ff <= 1'b0;
			buf_wr_ff  <= 1'b0;
		end else begin
			erase_p_ff <= go_erase;
			write_p_ff <= go_write;
			buf_wr_ff  <= go_fill;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			buf_word_ff <= 6'h00;
			buf_data_ff <= 16'h0000;
		end else if (go_fill) begin
			buf_word_ff <= ptr_word;
			buf_data_ff <= store_data_in;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			load_valid_ff <= 1'b0;
			load_allow_ff <= 1'b0;
			load_word_ff  <= 14'h0000;
			load_byte_ff  <= 1'b0;
		end else begin
			// a refused load still answers valid with allow low, so the core sees no fault
			load_valid_ff <= load_exec_in;
			load_allow_ff <= load_exec_in & load_ok;
			if (load_exec_in) begin
				load_word_ff <= ptr_word_addr;
				load_byte_ff <= pointer_ff[0];
			end
		end
	end

	// during a no-read-while-write operation the core must not fetch at all
	assign halt_core_out     = op_busy & nrw_op_ff;
	assign rww_busy_flag_out = rww_busy_ff;
	assign irq_disable_out   = irq_mask_app | irq_mask_loader;
	assign load_allow_out    = load_allow_ff;
	assign load_valid_out    = load_valid_ff;
	assign load_word_out     = load_word_ff;
	assign load_byte_sel_out = load_byte_ff;
	assign reset_vector_out  = reset_vector_ff;
	assign flash_erase_out   = erase_p_ff;
	assign flash_write_out   = write_p_ff;
	assign flash_page_out    = page_ff;
	assign buf_write_out     = buf_wr_ff;
	assign buf_word_out      = buf_word_ff;
	assign buf_data_out      = buf_data_ff;
	assign lock_bits_out     = {loader_lock_ff, app_lock_ff};

	////////////////////////////////////////////////////////////////////////////////
	// apb registers

	// pointer and lock data take writes while busy; the running page is already latched
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pointer_ff   <= 16'h0000;
			lock_data_ff <= 8'hFF;
		end else begin
			if (apb_wr && hit_pointer)
				pointer_ff <= pwdata_in[15:0];
			if (apb_wr && hit_ldata)
				lock_data_ff <= pwdata_in[7:0];
		end
	end

	wire [31:0] ctrl_rd   = {25'h0000000, rww_busy_ff, 1'b0, cmd_ff};
	// status mirrors the live lock fields and the captured fuse for software
	wire [31:0] status_rd = {23'h000000, gen_lock_s, boot_fuse_ff, halt_core_out, op_busy,
		loader_lock_ff, app_lock_ff};
	wire [31:0] rd_mux = hit_ctrl ? ctrl_rd
		: hit_pointer ? {16'h0000, pointer_ff}
		: hit_ldata ? {24'h000000, lock_data_ff}
		: hit_status ? status_rd
		: 32'h00000000;

	assign prdata_out  = (apb_access && !pwrite_in) ? rd_mux : 32'h00000000;
	// every register answers at once; refused commands stay silent, unmapped ones error
	assign pready_out  = 1'b1;
	assign pslverr_out = apb_access & ~hit_any;

endmodule // boot_flash_access_guard
`default_nettype wire

// ===== core/boot_flash_guard_pkg.sv
`default_nettype none
package boot_flash_guard_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ERASE,
		ST_WRITE
	} op_state_t;
	typedef logic [1:0] lock_field_t;
endpackage
`default_nettype wire

// ===== core/boot_flash_guard_regs.svh
`ifndef BOOT_FLASH_GUARD_REGS_SVH
`define BOOT_FLASH_GUARD_REGS_SVH

`define REG_CTRL          8'h00
`define REG_POINTER       8'h04
`define REG_LOCK_DATA     8'h08
`define REG_STATUS        8'h0C

`define CTRL_ENABLE_BIT   0
`define CTRL_ERASE_BIT    1
`define CTRL_WRITE_BIT    2
`define CTRL_LOCKSET_BIT  3
`define CTRL_REENABLE_BIT 4
`define CTRL_BUSY_BIT     6
`define CMD_FILL          5'h01
`define CMD_ERASE         5'h03
`define CMD_WRITE         5'h05
`define CMD_LOCKSET       5'h09
`define CMD_REENABLE      5'h11

`define WORD_BITS         6
`define ADDR_BITS         14
`define NRW_START         14'h3800
`define LOADER_START      14'h3800
`define APP_RESET_VECTOR  14'h0000

`define STORE_WINDOW_CYCLES 3'h4
`define CAPTURE_CYCLES      2'h3
`define LOCK_RESET        2'h0

`endif

// ===== dv/boot_flash_access_guard_tb.sv
`include "boot_flash_guard_regs.svh"
`default_nettype none
module boot_flash_access_guard_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic        store_exec_in = 0, load_exec_in = 0, vectors_in_loader_in = 0;
	logic        boot_reset_fuse_pin_in = 1, chip_erase_pin_in = 0, err;
	logic [7:0]  paddr_in = 0, lat = 8;
	logic [31:0] pwdata_in = 0, rd, prdata_out;
	logic [13:0] fetch_addr_in = 14'h3900, load_word_out, reset_vector_out;
	logic [15:0] store_data_in = 0, buf_data_out, ptr_v;
	logic [3:0]  nv_lock_pin_in = 4'hF, prog_lock_pin_in = 4'hF, lock_bits_out;
	logic [1:0]  gen_lock_mode_pin_in = 2'h3;
	logic        pready_out, pslverr_out, halt_core_out, rww_busy_flag_out, irq_disable_out;
	logic        load_allow_out, load_valid_out, load_byte_sel_out, flash_done_in;
	logic        flash_erase_out, flash_write_out, buf_write_out;
	logic [7:0]  flash_page_out;
	logic [5:0]  buf_word_out;
	int          fail_count = 0, total_checks = 0, cyc = 0, m_lock = 15, k;
	boot_flash_access_guard DUT (.clk_sys_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .fetch_addr_in,
		.store_exec_in, .store_data_in, .load_exec_in, .vectors_in_loader_in, .halt_core_out,
		.rww_busy_flag_out, .irq_disable_out, .load_allow_out, .load_valid_out, .load_word_out,
		.load_byte_sel_out, .reset_vector_out, .flash_done_in, .flash_erase_out,
		.flash_write_out, .flash_page_out, .buf_write_out, .buf_word_out, .buf_data_out,
		.lock_bits_out, .boot_reset_fuse_pin_in, .nv_lock_pin_in, .prog_lock_pin_in,
		.chip_erase_pin_in, .gen_lock_mode_pin_in);
	flash_array_model u_flash (.clk_sys_in, .rst_in, .erase_in(flash_erase_out),
		.write_in(flash_write_out), .lat_in(lat), .done_out(flash_done_in));
	initial forever #2.5 clk_sys_in = ~clk_sys_in;
	////////////////////////////////////////////////////////////////////////////////
	task conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel_in <= 1;
		penable_in <= 0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1;
		do @(posedge clk_sys_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
	endtask
	// pulses are sampled one edge after the store is taken
	task store(input logic [13:0] f);
		@(posedge clk_sys_in);
		store_exec_in <= 1;
		fetch_addr_in <= f;
		store_data_in <= 16'($urandom);
		@(posedge clk_sys_in);
		store_exec_in <= 0;
		@(posedge clk_sys_in);
	endtask
	task cmd(input logic [15:0] p, input logic [4:0] c, input logic [13:0] f);
		apb(1, `REG_POINTER, {16'h0, p});
		apb(1, `REG_CTRL, {27'h0, c});
		store(f);
	endtask
	task prog(input logic [4:0] c, input logic [7:0] pg, input logic [13:0] f);
		logic ok;
		ok = f >= 14'h3800 && (pg >= 8'hE0 ? m_lock[2] : m_lock[0]);
		lat <= 8'($urandom_range(60, 8));
		cmd({1'b0, pg, 6'($urandom), 1'b0}, c, f);
		chk(c == `CMD_ERASE ? flash_erase_out : flash_write_out, ok, "start");
		if (ok) begin
			chk(flash_page_out, pg, "page");
			chk(halt_core_out, pg >= 8'hE0, "halt");
			apb(1, `REG_POINTER, 32'h7FFE);
			@(posedge clk_sys_in);
			chk(flash_page_out, pg, "latched");
			for (k = 0; k < 80 && flash_done_in !== 1'b1; k++)
				@(posedge clk_sys_in);
			@(posedge clk_sys_in);
			chk(halt_core_out, 0, "halt_end");
			chk(rww_busy_flag_out, pg < 8'hE0, "busy");
			cmd(16'h0, `CMD_REENABLE, 14'h3900);
			@(posedge clk_sys_in);
			chk(rww_busy_flag_out, 0, "busy_clr");
		end
	endtask
	task lockset(input logic [7:0] v);
		apb(1, `REG_LOCK_DATA, {24'h0, v});
		m_lock &= v[5:2];
		cmd(16'($urandom), `CMD_LOCKSET, 14'h3A00);
		chk(lock_bits_out, m_lock, "lockset");
	endtask
	task loads_irqs();
		logic [15:0] p;
		for (int i = 0; i < 4; i++) begin
			p = (i[1] ? 16'h7000 : 16'h0) | 16'($urandom_range(16'h0FFF));
			apb(1, `REG_POINTER, {16'h0, p});
			load_exec_in <= 1;
			fetch_addr_in <= i[0] ? 14'h3900 : 14'h0100;
			vectors_in_loader_in <= i[1];
			@(posedge clk_sys_in);
			load_exec_in <= 0;
			@(posedge clk_sys_in);
			chk(load_valid_out, 1, "ld_valid");
			chk(load_allow_out, i == 1 ? m_lock[1] : i == 2 ? m_lock[3] : 1, "ld_allow");
			chk({load_word_out, load_byte_sel_out}, p[14:0], "ld_addr");
			chk(irq_disable_out, i == 2 ? !m_lock[1] : i == 1 ? !m_lock[3] : 0, "irq");
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h99b3d23a));
		repeat (12) @(posedge clk_sys_in);
		rst_in <= 0;
		repeat (8) @(posedge clk_sys_in);
		chk(reset_vector_out, 14'h0000, "vector");
		chk(lock_bits_out, 4'hF, "locks");
		apb(0, `REG_STATUS, 0);
		chk(rd, 32'h1CF, "status");
		apb(0, 8'h10, 0);
		chk({err, rd[30:0]}, 32'h80000000, "unmapped");
		loads_irqs();
		ptr_v = 16'($urandom);
		cmd(ptr_v, `CMD_FILL, 14'h3900);
		chk({buf_write_out, buf_word_out, buf_data_out}, {1'b1, ptr_v[6:1], store_data_in},
			"fill");
		// erase then write of the same page, as loader software must
		repeat (2) begin
			prog(`CMD_ERASE, 8'h10, 14'h3900);
			prog(`CMD_WRITE, 8'h10, 14'h3900);
			prog(`CMD_ERASE, 8'hE5, 14'h3900);
			prog(`CMD_WRITE, 8'hE5, 14'h3900);
		end
		prog(`CMD_ERASE, 8'h20, 14'h0100);
		apb(1, `REG_CTRL, {27'h0, `CMD_FILL});
		repeat (4) @(posedge clk_sys_in);
		store(14'h3900);
		chk(buf_write_out, 0, "lapsed");
		lockset(8'hFB);
		prog(`CMD_ERASE, 8'h20, 14'h3900);
		prog(`CMD_WRITE, 8'hE1, 14'h3900);
		lockset(8'hEF);
		prog(`CMD_ERASE, 8'hE1, 14'h3900);
		lockset(8'hFF);
		lockset(8'hC3);
		loads_irqs();
		chip_erase_pin_in <= 1;
		repeat (6) @(posedge clk_sys_in);
		chip_erase_pin_in <= 0;
		repeat (6) @(posedge clk_sys_in);
		chk(lock_bits_out, 4'hF, "chip_erase");
		rst_in <= 1;
		boot_reset_fuse_pin_in <= 0;
		nv_lock_pin_in <= 4'hA;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 0;
		repeat (8) @(posedge clk_sys_in);
		chk(reset_vector_out, 14'h3800, "vector");
		prog_lock_pin_in <= 4'h7;
		repeat (6) @(posedge clk_sys_in);
		chk(lock_bits_out, 4'h2, "pin_lock");
		conclude();
	end
endmodule // boot_flash_access_guard_tb
`default_nettype wire

// ===== dv/boot_flash_guard_chk.sv
`default_nettype none
module boot_flash_guard_chk (
	input wire logic        clk_sys_in, rst_in, load_exec_in, store_exec_in,
	input wire logic        vectors_in_loader_in, boot_reset_fuse_pin_in, chip_erase_pin_in,
	input wire logic        halt_core_out, rww_busy_flag_out, irq_disable_out,
	input wire logic        load_allow_out, load_valid_out, flash_done_in,
	input wire logic        flash_erase_out, flash_write_out, buf_write_out,
	input wire logic [13:0] fetch_addr_in, load_word_out, reset_vector_out,
	input wire logic [7:0]  flash_page_out,
	input wire logic [3:0]  lock_bits_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	wire logic prog   = flash_erase_out | flash_write_out;
	wire logic in_ldr = fetch_addr_in >= 14'h3800;
	wire logic no_read_while_write_region   = flash_page_out >= 8'hE0;
	wire logic ld_ldr = load_word_out >= 14'h3800;
	////////////////////////////////////////////////////////////////////////////////
	property p_rww;
		prog && !no_read_while_write_region |-> !halt_core_out ##1 rww_busy_flag_out;
	endproperty
	a_rww: assert property (p_rww) else $error("rww op halted or not busy");
	property p_no_read_while_write_region;
		prog && no_read_while_write_region |-> halt_core_out;
	endproperty
	a_no_read_while_write_region: assert property (p_no_read_while_write_region) else $error("no_read_while_write_region op without halt");
	property p_halt_span;
		halt_core_out |=> halt_core_out != $past(flash_done_in);
	endproperty
	a_halt_span: assert property (p_halt_span) else $error("halt span wrong");
	property p_vec_app;
		boot_reset_fuse_pin_in [*8] |-> reset_vector_out == 14'h0000;
	endproperty
	a_vec_app: assert property (p_vec_app) else $error("app reset vector");
	property p_vec_ldr;
		!boot_reset_fuse_pin_in [*8] |-> reset_vector_out == 14'h3800;
	endproperty
	a_vec_ldr: assert property (p_vec_ldr) else $error("loader reset vector");
	property p_ld_app;
		load_valid_out && $past(in_ldr) && !ld_ldr && !$past(lock_bits_out[1]) |-> !load_allow_out;
	endproperty
	a_ld_app: assert property (p_ld_app) else $error("app read not blocked");
	property p_ld_ldr;
		load_valid_out && !$past(in_ldr) && ld_ldr && !$past(lock_bits_out[3]) |-> !load_allow_out;
	endproperty
	a_ld_ldr: assert property (p_ld_ldr) else $error("loader read not blocked");
	property p_ld_free;
		load_exec_in && lock_bits_out == 4'hF |=> load_valid_out && load_allow_out;
	endproperty
	a_ld_free: assert property (p_ld_free) else $error("free load refused");
	property p_irq;
		irq_disable_out == ((!in_ldr && vectors_in_loader_in && !lock_bits_out[1])
			|| (in_ldr && !vectors_in_loader_in && !lock_bits_out[3]));
	endproperty
	a_irq: assert property (p_irq) else $error("irq disable wrong");
	property p_st_lock;
		prog |-> (no_read_while_write_region ? $past(lock_bits_out[2]) : $past(lock_bits_out[0]));
	endproperty
	a_st_lock: assert property (p_st_lock) else $error("store into locked section");
	property p_st_src;
		prog || buf_write_out |-> $past(store_exec_in) && $past(in_ldr);
	endproperty
	a_st_src: assert property (p_st_src) else $error("store from app section");
	property p_lock_mono;
		!chip_erase_pin_in [*8] |-> (lock_bits_out & ~$past(lock_bits_out)) == 4'h0;
	endproperty
	a_lock_mono: assert property (p_lock_mono) else $error("lock bit cleared");
endmodule // boot_flash_guard_chk
bind boot_flash_access_guard boot_flash_guard_chk u_chk (.clk_sys_in, .rst_in, .load_exec_in,
	.store_exec_in, .vectors_in_loader_in, .boot_reset_fuse_pin_in, .chip_erase_pin_in,
	.halt_core_out, .rww_busy_flag_out, .irq_disable_out, .load_allow_out, .load_valid_out,
	.flash_done_in, .flash_erase_out, .flash_write_out, .buf_write_out, .fetch_addr_in,
	.load_word_out, .reset_vector_out, .flash_page_out, .lock_bits_out);
`default_nettype wire

// ===== dv/flash_array_model.sv
`default_nettype none
module flash_array_model (
	input wire logic       clk_sys_in,
	input wire logic       rst_in,
	input wire logic       erase_in,
	input wire logic       write_in,
	input wire logic [7:0] lat_in,
	output var logic       done_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// cell timing is abstract: lat_in cycles, so both prompt and slow arrays are seen
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 0;
			done_out <= 1'b0;
		end else begin
			done_out <= cnt == 1;
			if (erase_in || write_in)
				cnt <= lat_in;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule // flash_array_model
`default_nettype wire
